//--- hdl/scc_clock_config.sv
// system clock configuration register with glitch-free apply and clock enables
module scc_clock_config
	import scc_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [SCC_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [4:0]            input_div_strap,
	output logic                       pll_select,
	output logic                       tcm_mode,
	output logic      [2:0]            pll_band,
	output logic      [2:0]            pll_output_div,
	output logic      [4:0]            input_divider_value,
	output logic      [7:0]            feedback_divider_value,
	output logic                       pri_core_en,
	output logic                       sec_core_en,
	output logic                       sys_en,
	output logic                       pri_bus_en,
	output logic                       sec_bus_en,
	output logic                       apply_busy
);

	// ****************************************
	// helpers
	// ****************************************
	// core divider code to terminal count (divide minus one)
	function automatic logic [3:0] scc_core_last(input logic [2:0] code);
		case (code)
			3'h1:    scc_core_last = 4'h1;
			3'h2:    scc_core_last = 4'h2;
			3'h3:    scc_core_last = 4'h3;
			3'h4:    scc_core_last = 4'h5;
			3'h5:    scc_core_last = 4'h7;
			3'h6:    scc_core_last = 4'h9;
			default: scc_core_last = 4'hB;
		endcase
	endfunction

	logic [31:0]      cfg_r;
	logic [2:0]       act_pri_r;
	logic [2:0]       act_sec_r;
	logic [1:0]       act_sys_r;
	logic [1:0]       act_secbus_r;
	logic [3:0]       pri_cnt_r;
	logic [3:0]       sec_cnt_r;
	logic [1:0]       sys_cnt_r;
	logic [1:0]       secbus_cnt_r;
	logic [4:0]       strap_s1_r;
	logic [4:0]       strap_s2_r;
	logic [1:0]       strap_vld_r;
	logic             strap_done_r;
	scc_apply_e       apl_r;
	logic             pri_wrap;
	logic             sec_wrap;
	logic             sys_wrap;
	logic             secbus_wrap;
	logic             setup;
	logic             access;
	logic             hit_cfg;
	logic             hit_apply;
	logic             kick;
	logic             commit_pri;
	logic             commit_sec;

	// ****************************************
	// register bus decode
	// ****************************************
	assign setup     = psel && !penable;
	assign access    = psel && penable && pready;
	assign hit_cfg   = (paddr == SCC_OFF_CFG);
	assign hit_apply = (paddr == SCC_OFF_APPLY);
	assign kick      = access && pwrite && hit_apply && pwdata[SCC_KICK_BIT];

	// answer prepared in setup so data and ready come straight from flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (setup) begin
			pready  <= 1'b1;
			pslverr <= !(hit_cfg || hit_apply);
			prdata  <= 32'h0000_0000;
			if (!pwrite && hit_cfg)
				prdata <= cfg_r;
			else if (!pwrite && hit_apply)
				prdata[SCC_BUSY_BIT] <= (apl_r != SCC_APL_IDLE);
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// ****************************************
	// strap capture for the input divider
	// ****************************************
	// pins are asynchronous: two stages before anything looks at them
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_s1_r  <= 5'h00;
			strap_s2_r  <= 5'h00;
			strap_vld_r <= 2'h0;
		end else begin
			strap_s1_r  <= input_div_strap;
			strap_s2_r  <= strap_s1_r;
			strap_vld_r <= {strap_vld_r[0], 1'b1};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			strap_done_r <= 1'b0;
		else if (strap_vld_r[SCC_STRAP_SYNC-1])
			strap_done_r <= 1'b1;
	end

	// ****************************************
	// configuration register
	// ****************************************
	// a software write in the capture cycle wins over the strap
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r <= SCC_CFG_RST;
		end else if (access && pwrite && hit_cfg) begin
			cfg_r <= pwdata;
		end else if (strap_vld_r[SCC_STRAP_SYNC-1] && !strap_done_r) begin
			cfg_r[SCC_INDIV_LSB +: 5] <= strap_s2_r;
		end
	end

	// ****************************************
	// divider chains
	// ****************************************
	// the clk itself stands for the selected PLL output
	assign pri_wrap    = (pri_cnt_r == scc_core_last(act_pri_r));
	assign sec_wrap    = (sec_cnt_r == scc_core_last(act_sec_r));
	assign sys_wrap    = pri_wrap && (sys_cnt_r == act_sys_r);
	assign secbus_wrap = sec_wrap && (secbus_cnt_r == act_secbus_r);

	// primary core and system chain
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pri_cnt_r <= 4'h0;
			sys_cnt_r <= 2'h0;
		end else begin
			pri_cnt_r <= pri_wrap ? 4'h0 : pri_cnt_r + 4'h1;
			if (sys_wrap)
				sys_cnt_r <= 2'h0;
			else if (pri_wrap)
				sys_cnt_r <= sys_cnt_r + 2'h1;
		end
	end

	// secondary core chain; its bus ratio only gates, never paces sys
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sec_cnt_r    <= 4'h0;
			secbus_cnt_r <= 2'h0;
		end else begin
			sec_cnt_r <= sec_wrap ? 4'h0 : sec_cnt_r + 4'h1;
			if (secbus_wrap)
				secbus_cnt_r <= 2'h0;
			else if (sec_wrap)
				secbus_cnt_r <= secbus_cnt_r + 2'h1;
		end
	end

	// enables registered so each output is a flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pri_core_en <= 1'b0;
			sec_core_en <= 1'b0;
			sys_en      <= 1'b0;
			pri_bus_en  <= 1'b0;
			sec_bus_en  <= 1'b0;
		end else begin
			pri_core_en <= pri_wrap;
			sec_core_en <= sec_wrap;
			sys_en      <= sys_wrap;
			pri_bus_en  <= sys_wrap;
			sec_bus_en  <= secbus_wrap;
		end
	end

	// ****************************************
	// apply sequencer
	// ****************************************
	// each half switches on its own period boundary so no pulse is cut short
	assign commit_pri = sys_wrap && (apl_r == SCC_APL_BOTH || apl_r == SCC_APL_PRI);
	assign commit_sec = secbus_wrap && (apl_r == SCC_APL_BOTH || apl_r == SCC_APL_SEC);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			apl_r <= SCC_APL_IDLE;
		end else if (kick) begin
			apl_r <= SCC_APL_BOTH;
		end else begin
			case (apl_r)
				SCC_APL_BOTH: begin
					if (commit_pri && commit_sec)
						apl_r <= SCC_APL_IDLE;
					else if (commit_pri)
						apl_r <= SCC_APL_SEC;
					else if (commit_sec)
						apl_r <= SCC_APL_PRI;
				end
				SCC_APL_PRI: if (commit_pri) apl_r <= SCC_APL_IDLE;
				SCC_APL_SEC: if (commit_sec) apl_r <= SCC_APL_IDLE;
				default:     apl_r <= SCC_APL_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			apply_busy <= 1'b0;
		else
			apply_busy <= kick || (apl_r != SCC_APL_IDLE && !(apl_r == SCC_APL_BOTH
				&& commit_pri && commit_sec) && !(apl_r == SCC_APL_PRI && commit_pri)
				&& !(apl_r == SCC_APL_SEC && commit_sec));
	end

	// ****************************************
	// active settings
	// ****************************************
	// primary half: source, memory mode, PLL fields, core and system ratios
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			act_pri_r              <= SCC_CFG_RST[SCC_PRIDIV_LSB +: 3];
			act_sys_r              <= SCC_CFG_RST[SCC_SYSDIV_LSB +: 2];
			pll_select             <= SCC_CFG_RST[SCC_PLLSEL_BIT];
			tcm_mode               <= SCC_CFG_RST[SCC_TCM_BIT];
			pll_band               <= SCC_CFG_RST[SCC_BAND_LSB +: 3];
			pll_output_div         <= SCC_CFG_RST[SCC_OUTDIV_LSB +: 3];
			input_divider_value    <= SCC_CFG_RST[SCC_INDIV_LSB +: 5];
			feedback_divider_value <= SCC_CFG_RST[SCC_FBDIV_LSB +: 8];
		end else if (commit_pri) begin
			act_pri_r              <= cfg_r[SCC_PRIDIV_LSB +: 3];
			act_sys_r              <= cfg_r[SCC_SYSDIV_LSB +: 2];
			pll_select             <= cfg_r[SCC_PLLSEL_BIT];
			tcm_mode               <= cfg_r[SCC_TCM_BIT];
			pll_band               <= cfg_r[SCC_BAND_LSB +: 3];
			pll_output_div         <= cfg_r[SCC_OUTDIV_LSB +: 3];
			input_divider_value    <= cfg_r[SCC_INDIV_LSB +: 5];
			feedback_divider_value <= cfg_r[SCC_FBDIV_LSB +: 8];
		end
	end

	// secondary half: core divider and bus enable ratio
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			act_sec_r    <= SCC_CFG_RST[SCC_SECDIV_LSB +: 3];
			act_secbus_r <= SCC_CFG_RST[SCC_SECBUS_LSB +: 2];
		end else if (commit_sec) begin
			act_sec_r    <= cfg_r[SCC_SECDIV_LSB +: 3];
			act_secbus_r <= cfg_r[SCC_SECBUS_LSB +: 2];
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_write_cfg;
		psel && penable && pready && pwrite && hit_cfg;
	endsequence

	a_sys_on_pri: assert property (sys_en |-> pri_core_en)
		else $error("system enable without primary core enable");
	a_pri_min_gap: assert property (pri_core_en |=> !pri_core_en)
		else $error("primary core enable closer than divide by two");
	a_sec_min_gap: assert property (sec_core_en |=> !sec_core_en)
		else $error("secondary core enable closer than divide by two");
	a_secbus_gated: assert property (sec_bus_en |-> sec_core_en)
		else $error("secondary bus enable outside a core enable");
	a_pribus_follows: assert property (pri_bus_en == sys_en)
		else $error("primary bus enable differs from system enable");
	a_cfg_written: assert property (s_write_cfg |=> cfg_r == $past(pwdata))
		else $error("configuration write not stored");
	a_hold_no_kick: assert property ((apl_r == SCC_APL_IDLE && !kick)
		|=> $stable(pll_select) && $stable(act_pri_r))
		else $error("active setting changed without apply");
	a_switch_edge: assert property ($changed(tcm_mode) || $changed(act_pri_r)
		|-> sys_en)
		else $error("primary settings switched off a period boundary");
	a_strap_taken: assert property ($rose(strap_done_r)
		&& !$past(psel && penable && pready && pwrite && hit_cfg)
		|-> cfg_r[SCC_INDIV_LSB +: 5] == $past(strap_s2_r))
		else $error("strap level not loaded into input divider");
	a_kick_busy: assert property (kick |=> apply_busy ##0 (apl_r == SCC_APL_BOTH))
		else $error("apply kick not registered");
endmodule

//--- pkg/scc_pkg.sv
// constants for the system clock configuration register block
package scc_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam int          SCC_ADDR_W     = 12;
	localparam logic [11:0] SCC_OFF_CFG    = 12'h000;
	localparam logic [11:0] SCC_OFF_APPLY  = 12'h008;
	localparam logic [31:0] SCC_CFG_RST    = 32'h0CC0_0000;

	// ****************************************
	// field positions of the configuration word
	// ****************************************
	localparam int SCC_SECBUS_LSB = 30;
	localparam int SCC_TCM_BIT    = 29;
	localparam int SCC_SECDIV_LSB = 26;
	localparam int SCC_PLLSEL_BIT = 25;
	localparam int SCC_PRIDIV_LSB = 22;
	localparam int SCC_SYSDIV_LSB = 20;
	localparam int SCC_BAND_LSB   = 16;
	localparam int SCC_OUTDIV_LSB = 13;
	localparam int SCC_INDIV_LSB  = 8;
	localparam int SCC_FBDIV_LSB  = 0;

	// ****************************************
	// apply register bits
	// ****************************************
	localparam int SCC_KICK_BIT = 0;
	localparam int SCC_BUSY_BIT = 1;

	// pipeline depth before the strap levels are trusted
	localparam int SCC_STRAP_SYNC = 2;

	// apply sequencer: which halves still wait for their boundary
	typedef enum logic [1:0] {
		SCC_APL_IDLE,
		SCC_APL_BOTH,
		SCC_APL_PRI,
		SCC_APL_SEC
	} scc_apply_e;
endpackage

//--- bench/tb.sv
// self-checking bench for the system clock configuration register
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import scc_pkg::*;

	`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin bad_count++; \
		$display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); end end

	logic                  clk = 1'b0;
	logic                  rst_n = 1'b0;
	logic                  psel = 1'b0;
	logic                  penable = 1'b0;
	logic                  pwrite = 1'b0;
	logic [SCC_ADDR_W-1:0] paddr = '0;
	logic [31:0]           pwdata = '0;
	logic [31:0]           prdata;
	logic                  pready;
	logic                  pslverr;
	logic [4:0]            input_div_strap = 5'h15;
	logic                  pll_select;
	logic                  tcm_mode;
	logic [2:0]            pll_band;
	logic [2:0]            pll_output_div;
	logic [4:0]            input_divider_value;
	logic [7:0]            feedback_divider_value;
	logic                  pri_core_en;
	logic                  sec_core_en;
	logic                  sys_en;
	logic                  pri_bus_en;
	logic                  sec_bus_en;
	logic                  apply_busy;
	logic [4:0]            ens;
	int                    bad_count = 0;
	int                    num_checks = 0;

	// ****************************************
	// clock, dut and enable bundle
	// ****************************************
	always #20 clk = ~clk;

	assign ens = {sec_bus_en, pri_bus_en, sys_en, sec_core_en, pri_core_en};

	scc_clock_config i_dut (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .input_div_strap(input_div_strap), .pll_select(pll_select),
		.tcm_mode(tcm_mode), .pll_band(pll_band), .pll_output_div(pll_output_div),
		.input_divider_value(input_divider_value),
		.feedback_divider_value(feedback_divider_value), .pri_core_en(pri_core_en),
		.sec_core_en(sec_core_en), .sys_en(sys_en), .pri_bus_en(pri_bus_en),
		.sec_bus_en(sec_bus_en), .apply_busy(apply_busy)
	);

	// ****************************************
	// bus and measurement tasks
	// ****************************************
	// one apb transfer; the answer is taken at the rising edge that samples pready high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// request held until the edge that sees pready; values read here are pre-edge
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// kick the apply trigger and wait for both halves to commit
	task automatic kick();
		logic [31:0] r;
		logic        e;
		int          n;
		// settings change only here, and the next change waits for this switch to finish
		apb(1'b1, SCC_OFF_APPLY, 32'h0000_0001, r, e);
		n = 0;
		do begin @(negedge clk); n++; end while (apply_busy !== 1'b0 && n < 300);
		`CHK(apply_busy, 1'b0)
	endtask

	// cycles between two pulses of one enable
	task automatic period(input int s, output int p);
		int n;
		n = 0;
		do begin @(negedge clk); n++; end while (ens[s] !== 1'b1 && n < 200);
		p = 0;
		do begin @(negedge clk); p++; end while (ens[s] !== 1'b1 && p < 200);
	endtask

	function automatic int dv(input int c);
		case (c)
			1: dv = 2;
			2: dv = 3;
			3: dv = 4;
			4: dv = 6;
			5: dv = 8;
			6: dv = 10;
			default: dv = 12;
		endcase
	endfunction

	// ****************************************
	// verdict
	// ****************************************
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// watchdog sized well above the expected run of well under two thousand cycles
	initial begin
		#(40 * 30000);
		bad_count++;
		wrap_up();
	end

	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		logic [31:0] r;
		logic [31:0] w;
		logic [2:0]  c;
		logic        e;
		int          p;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		// reset image with strap levels in the input divider field
		apb(1'b0, SCC_OFF_CFG, '0, r, e);
		`CHK(r, SCC_CFG_RST | 32'h0000_1500)
		`CHK(e, 1'b0)
		`CHK(input_divider_value, 5'h00)
		`CHK(feedback_divider_value, 8'h00)
		`CHK(pll_output_div, 3'h0)
		`CHK(pll_select, 1'b0)
		period(0, p); `CHK(p, 4)
		period(1, p); `CHK(p, 4)
		period(2, p); `CHK(p, 4)
		// apply register idle after reset
		apb(1'b0, SCC_OFF_APPLY, '0, r, e);
		`CHK(r, 32'h0000_0000)
		`CHK(e, 1'b0)
		// unmapped places refuse and leave the register alone
		apb(1'b0, 12'h004, '0, r, e);
		`CHK(e, 1'b1)
		`CHK(r, 32'h0000_0000)
		apb(1'b1, 12'h010, 32'hFFFF_FFFF, r, e);
		`CHK(e, 1'b1)
		apb(1'b0, SCC_OFF_CFG, '0, r, e);
		`CHK(r, SCC_CFG_RST | 32'h0000_1500)
		// every divider code, ratio and select, held back until the kick
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			w = {c[1:0], c[0], ~c, c[0], c, c[1:0], 1'b0, c, c, 5'(i * 3), 8'(i * 37)};
			apb(1'b1, SCC_OFF_CFG, w, r, e);
			apb(1'b0, SCC_OFF_CFG, '0, r, e);
			`CHK(r, w)
			`CHK(pll_band, (i == 0) ? 3'h0 : c - 3'h1)
			kick();
			`CHK(pll_select, c[0])
			`CHK(tcm_mode, c[0])
			`CHK(pll_band, c)
			`CHK(pll_output_div, c)
			`CHK(input_divider_value, 5'(i * 3))
			`CHK(feedback_divider_value, 8'(i * 37))
			period(0, p); `CHK(p, dv(i))
			period(1, p); `CHK(p, dv(7 - i))
			period(2, p); `CHK(p, dv(i) * (i % 4 + 1))
			period(3, p); `CHK(p, dv(i) * (i % 4 + 1))
			period(4, p); `CHK(p, dv(7 - i) * (i % 4 + 1))
		end
		wrap_up();
	end
endmodule
